// [core/iracc_core.sv]
// Purpose: Executes input-read, set-output and accumulator-calculate
//          commands from a host byte stream or from a stored program.
// Assumes: Inputs are synchronous to clk_i; converter results arrive
//          already conditioned; the transport link lies outside.
// Notes:   Direct frames are ignored while standalone_i is high.
`timescale 1ns/1ps
`default_nettype none

module iracc_core #(
    parameter logic [7:0] TARGET_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR = 8'h02
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standalone_i,
    input wire logic [7:0] cmd_byte_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire iracc_pkg::iracc_cmd_t prog_cmd_i,
    input wire logic prog_valid_i,
    input wire logic [7:0] din_i,
    input wire logic enable_i,
    input wire logic [7:0][9:0] adc_raw_i,
    input wire logic [15:0] supply_dv_i,
    input wire logic [15:0] temp_c_i,
    input wire logic rpl_ready_i,
    output logic [7:0] rpl_byte_o,
    output logic rpl_valid_o,
    output logic [7:0] dout_o,
    output logic [31:0] acc_o
);
    import iracc_pkg::*;

    iracc_state_t state_ff;
    iracc_state_t nxt_state;
    iracc_cmd_t frame_cmd;
    iracc_cmd_t exec_cmd;
    iracc_frame_t reply;
    logic chk_ok;
    logic frame_go;
    logic exec_en;
    logic [31:0] rd_val;
    logic [31:0] rpl_val;

    // Modulo-256 sum of every byte except the trailing checksum.
    function automatic logic [7:0] sum8(input iracc_frame_t f);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < FRAME_LEN - 1; i++) begin
            s = s + f[i];
        end
        return s;
    endfunction

    function automatic logic known(input logic [7:0] instr);
        return instr == INSTR_READ || instr == INSTR_MATH ||
            instr == INSTR_SET;
    endfunction

    // Port read; unknown ports and banks read as zero.
    function automatic logic [31:0] port_read(
        input logic [7:0] port,
        input logic [7:0] bank,
        input logic [7:0] din,
        input logic en,
        input logic [7:0][9:0] adc,
        input logic [15:0] sup,
        input logic [15:0] tmp,
        input logic [7:0] dout
    );
        logic [31:0] r;
        r = 32'h00000000;
        if (bank == BANK_DIN) begin
            // Analog pins are wired into din_i as well, so both views coexist.
            if (port < PORT_LINES) begin
                r = {31'h00000000, din[port[2:0]]};
            end else if (port == PORT_ENABLE) begin
                r = {31'h00000000, en};
            end else if (port == PORT_ALL) begin
                r = {24'h000000, din};
            end
        end else if (bank == BANK_ADC) begin
            if (port < PORT_LINES) begin
                r = {{(32-ADC_BITS){1'b0}}, adc[port[2:0]]};
            end else if (port == PORT_SUPPLY) begin
                r = {16'h0000, sup};
            end else if (port == PORT_TEMP) begin
                r = {{16{tmp[15]}}, tmp};
            end
        end else if (bank == BANK_DOUT && port < PORT_LINES) begin
            r = {31'h00000000, dout[port[2:0]]};
        end
        return r;
    endfunction

    // Signed accumulator arithmetic; division by zero keeps the old value
    // rather than inventing a result.
    function automatic logic [31:0] acc_op(
        input logic [7:0] op,
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic [31:0] r;
        r = a;
        case (op)
            OP_ADD: r = a + b;
            OP_SUB: r = a - b;
            OP_MUL: r = $signed(a) * $signed(b);
            OP_DIV: if (b != 32'h00000000) r = $signed(a) / $signed(b);
            OP_MOD: if (b != 32'h00000000) r = $signed(a) % $signed(b);
            OP_AND: r = a & b;
            OP_OR: r = a | b;
            OP_XOR: r = a ^ b;
            OP_NOT: r = ~a;
            OP_LOAD: r = b;
            default: r = a;
        endcase
        return r;
    endfunction

    // Reply frame: host, target, status, instruction, value, checksum.
    function automatic iracc_frame_t build_reply(
        input logic [7:0] host,
        input logic [7:0] tgt,
        input logic [7:0] instr,
        input logic [31:0] v
    );
        iracc_frame_t f;
        f = '0;
        f[0] = host;
        f[1] = tgt;
        f[2] = STATUS_OK;
        f[3] = instr;
        f[4] = v[31:24];
        f[5] = v[23:16];
        f[6] = v[15:8];
        f[7] = v[7:0];
        f[8] = sum8(f);
        return f;
    endfunction

    // Received bytes in order: address, instruction, type, bank, value.
    assign frame_cmd.addr = state_ff.rx_buf[0];
    assign frame_cmd.instr = state_ff.rx_buf[1];
    assign frame_cmd.typ = state_ff.rx_buf[2];
    assign frame_cmd.bank = state_ff.rx_buf[3];
    assign frame_cmd.value = {state_ff.rx_buf[4], state_ff.rx_buf[5],
        state_ff.rx_buf[6], state_ff.rx_buf[7]};
    assign chk_ok = sum8(state_ff.rx_buf) == state_ff.rx_buf[8];

    // Frames with a bad sum, foreign address or unknown code are dropped.
    assign frame_go = !standalone_i && state_ff.st == ST_EXEC && chk_ok &&
        frame_cmd.addr == TARGET_ADDR && known(frame_cmd.instr);
    assign exec_cmd = standalone_i ? prog_cmd_i : frame_cmd;
    assign exec_en = standalone_i ? (prog_valid_i && known(prog_cmd_i.instr))
        : frame_go;
    assign rd_val = port_read(exec_cmd.typ, exec_cmd.bank, din_i, enable_i,
        adc_raw_i, supply_dv_i, temp_c_i, state_ff.dout);
    assign rpl_val = (exec_cmd.instr == INSTR_READ) ? rd_val :
        (exec_cmd.instr == INSTR_MATH) ? exec_cmd.value : 32'h00000000;
    assign reply = build_reply(HOST_ADDR, TARGET_ADDR, exec_cmd.instr,
        rpl_val);

    // Next-state logic for the frame sequencer and the executed command.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff.st)
            ST_RX: begin
                if (cmd_valid_i && state_ff.ready_o) begin
                    nxt_state.rx_buf[state_ff.cnt] = cmd_byte_i;
                    if (state_ff.cnt == LAST_IDX) begin
                        nxt_state.cnt = 4'h0;
                        nxt_state.st = ST_EXEC;
                        nxt_state.ready_o = 1'b0;
                    end else begin
                        nxt_state.cnt = state_ff.cnt + 4'h1;
                    end
                end
            end
            ST_EXEC: begin
                nxt_state.st = ST_RX;
                nxt_state.ready_o = 1'b1;
                if (frame_go) begin
                    nxt_state.tx_buf = reply;
                    nxt_state.st = ST_TX;
                    nxt_state.ready_o = 1'b0;
                    nxt_state.byte_o = reply[0];
                    nxt_state.valid_o = 1'b1;
                end
            end
            ST_TX: begin
                // A byte moves on valid and ready; it holds while stalled.
                if (rpl_ready_i) begin
                    if (state_ff.cnt == LAST_IDX) begin
                        nxt_state.cnt = 4'h0;
                        nxt_state.valid_o = 1'b0;
                        nxt_state.st = ST_RX;
                        nxt_state.ready_o = 1'b1;
                    end else begin
                        nxt_state.cnt = state_ff.cnt + 4'h1;
                        nxt_state.byte_o =
                            state_ff.tx_buf[state_ff.cnt + 4'h1];
                    end
                end
            end
        endcase
        if (exec_en) begin
            if (exec_cmd.instr == INSTR_READ) begin
                // The all-inputs vector goes to the accumulator in any mode.
                if (standalone_i) begin
                    nxt_state.acc = rd_val;
                end else if (exec_cmd.bank == BANK_DIN &&
                        exec_cmd.typ == PORT_ALL) begin
                    nxt_state.acc = rd_val;
                end
            end else if (exec_cmd.instr == INSTR_MATH) begin
                nxt_state.acc = acc_op(exec_cmd.typ, state_ff.acc,
                    exec_cmd.value);
            end else if (exec_cmd.bank == BANK_DOUT) begin
                if (exec_cmd.typ < PORT_LINES) begin
                    nxt_state.dout[exec_cmd.typ[2:0]] = exec_cmd.value[0];
                end else if (exec_cmd.typ == PORT_ALL) begin
                    nxt_state.dout = (exec_cmd.value == VALUE_FROM_ACC) ?
                        state_ff.acc[7:0] : exec_cmd.value[7:0];
                end
            end
        end
    end

    // State register; every output is a field of it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= '0;
            state_ff.st <= ST_RX;
            state_ff.acc <= ACC_RST;
            state_ff.dout <= DOUT_RST;
            state_ff.ready_o <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cmd_ready_o = state_ff.ready_o;
    assign rpl_byte_o = state_ff.byte_o;
    assign rpl_valid_o = state_ff.valid_o;
    assign dout_o = state_ff.dout;
    assign acc_o = state_ff.acc;

    // Checks on the executor.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_read_stand_acc: assert property (
        standalone_i && exec_en && exec_cmd.instr == INSTR_READ
        |=> acc_o == $past(rd_val))
        else $error("standalone read did not load accumulator");
    a_read_direct_acc: assert property (
        frame_go && frame_cmd.instr == INSTR_READ &&
        frame_cmd.typ != PORT_ALL |=> $stable(acc_o))
        else $error("direct read changed accumulator");
    a_din_all: assert property (
        exec_en && exec_cmd.instr == INSTR_READ &&
        exec_cmd.bank == BANK_DIN && exec_cmd.typ == PORT_ALL
        |=> acc_o == {24'h000000, $past(din_i)})
        else $error("input vector not in accumulator");
    a_adc_range: assert property (
        exec_cmd.bank == BANK_ADC && exec_cmd.typ < PORT_LINES
        |-> rd_val <= 32'h000003FF)
        else $error("converter value out of range");
    a_enable_port: assert property (
        exec_cmd.bank == BANK_DIN && exec_cmd.typ == PORT_ENABLE
        |-> rd_val == {31'h00000000, enable_i})
        else $error("enable port read wrong");
    a_math_add: assert property (
        exec_en && exec_cmd.instr == INSTR_MATH && exec_cmd.typ == OP_ADD
        |=> acc_o == $past(acc_o) + $past(exec_cmd.value))
        else $error("add result wrong");
    a_math_load: assert property (
        exec_en && exec_cmd.instr == INSTR_MATH && exec_cmd.typ == OP_LOAD
        |=> acc_o == $past(exec_cmd.value))
        else $error("load result wrong");
    a_out_vector: assert property (
        exec_en && exec_cmd.instr == INSTR_SET &&
        exec_cmd.bank == BANK_DOUT && exec_cmd.typ == PORT_ALL &&
        exec_cmd.value != VALUE_FROM_ACC
        |=> dout_o == $past(exec_cmd.value[7:0]))
        else $error("output vector not applied");
    a_reply_status: assert property (
        rpl_valid_o && state_ff.cnt == STATUS_IDX |-> rpl_byte_o == STATUS_OK)
        else $error("reply status not OK");
    a_reply_chksum: assert property (
        rpl_valid_o && state_ff.cnt == LAST_IDX
        |-> rpl_byte_o == sum8(state_ff.tx_buf))
        else $error("reply checksum wrong");
    a_bad_frame: assert property (
        state_ff.st == ST_EXEC && !chk_ok |=> !rpl_valid_o ##1 cmd_ready_o)
        else $error("bad frame was answered");
    a_tx_hold: assert property (
        rpl_valid_o && !rpl_ready_i |=> rpl_valid_o && $stable(rpl_byte_o))
        else $error("reply byte dropped under stall");

    c_direct_read: cover property (frame_go && frame_cmd.instr == INSTR_READ
        ##[1:40] rpl_valid_o && state_ff.cnt == LAST_IDX && rpl_ready_i);
    c_stand_math: cover property (standalone_i && exec_en &&
        exec_cmd.instr == INSTR_MATH);
    c_out_from_acc: cover property (exec_en && exec_cmd.instr == INSTR_SET &&
        exec_cmd.value == VALUE_FROM_ACC);
endmodule

`default_nettype wire

// [core/iracc_pkg.sv]
// Purpose: Shared constants and types for the I/O read and accumulator
//          command executor.
// Assumes: Nine-byte command and reply frames, one byte per handshake.
// Notes:   Bank and port numbers are the values seen in the frame bytes.
package iracc_pkg;
    // Frame geometry.
    localparam int FRAME_LEN = 9;
    localparam logic [3:0] LAST_IDX = 4'h8;
    localparam logic [3:0] STATUS_IDX = 4'h2;
    // Instruction codes and the reply status code.
    localparam logic [7:0] INSTR_SET = 8'h0E;
    localparam logic [7:0] INSTR_READ = 8'h0F;
    localparam logic [7:0] INSTR_MATH = 8'h13;
    localparam logic [7:0] STATUS_OK = 8'h64;
    // Banks, special ports and the from-accumulator value.
    localparam logic [7:0] BANK_DIN = 8'h00;
    localparam logic [7:0] BANK_ADC = 8'h01;
    localparam logic [7:0] BANK_DOUT = 8'h02;
    localparam logic [7:0] PORT_LINES = 8'h08;
    localparam logic [7:0] PORT_SUPPLY = 8'h08;
    localparam logic [7:0] PORT_TEMP = 8'h09;
    localparam logic [7:0] PORT_ENABLE = 8'h0A;
    localparam logic [7:0] PORT_ALL = 8'hFF;
    localparam logic [31:0] VALUE_FROM_ACC = 32'hFFFFFFFF;
    // Calculate operation codes.
    localparam logic [7:0] OP_ADD = 8'h00;
    localparam logic [7:0] OP_SUB = 8'h01;
    localparam logic [7:0] OP_MUL = 8'h02;
    localparam logic [7:0] OP_DIV = 8'h03;
    localparam logic [7:0] OP_MOD = 8'h04;
    localparam logic [7:0] OP_AND = 8'h05;
    localparam logic [7:0] OP_OR = 8'h06;
    localparam logic [7:0] OP_XOR = 8'h07;
    localparam logic [7:0] OP_NOT = 8'h08;
    localparam logic [7:0] OP_LOAD = 8'h09;
    // Widths and reset values.
    localparam int ADC_BITS = 10;
    localparam int NUM_LINES = 8;
    localparam logic [31:0] ACC_RST = 32'h00000000;
    localparam logic [7:0] DOUT_RST = 8'h00;

    typedef logic [FRAME_LEN-1:0][7:0] iracc_frame_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] instr;
        logic [7:0] typ;
        logic [7:0] bank;
        logic [31:0] value;
    } iracc_cmd_t;

    typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} iracc_st_t;

    typedef struct packed {
        iracc_st_t st;
        logic [3:0] cnt;
        iracc_frame_t rx_buf;
        iracc_frame_t tx_buf;
        logic [31:0] acc;
        logic [7:0] dout;
        logic [7:0] byte_o;
        logic valid_o;
        logic ready_o;
    } iracc_state_t;
endpackage

// [tb/iracc_host_model.sv]
// Purpose: Host side of the command link: sends frames, drains replies.
// Assumes: Tasks are entered just after a rising edge of clk_i.
// Notes:   A slow host drops reply ready on every other cycle.
`timescale 1ns/1ps
`default_nettype none
module iracc_host_model
    import iracc_pkg::*;
#(
    parameter logic [7:0] HOST_ADDR = 8'h02,
    parameter logic [7:0] TARGET_ADDR = 8'h01
) (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic cmd_ready_i,
    output var logic [7:0] cmd_byte_o,
    output var logic cmd_valid_o,
    input wire logic [7:0] rpl_byte_i,
    input wire logic rpl_valid_i,
    output var logic rpl_ready_o
);
    // The link starts idle.
    initial begin
        cmd_byte_o = 8'h00;
        cmd_valid_o = 1'b0;
        rpl_ready_o = 1'b0;
    end

    // Offers the frame byte by byte; err spoils the checksum on purpose.
    task automatic send_frame(input iracc_cmd_t c, input logic [7:0] err);
        logic [7:0] b [9];
        int k;
        b = '{c.addr, c.instr, c.typ, c.bank, c.value[31:24],
              c.value[23:16], c.value[15:8], c.value[7:0], 8'h00};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        b[8] += err;
        for (int i = 0; i < 9; i++) begin
            cmd_byte_o = b[i];
            cmd_valid_o = 1'b1;
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (!cmd_ready_i && k < 64);
            #1;
        end
        cmd_valid_o = 1'b0;
        // A released line shows the inverse, so a stale byte cannot pass.
        cmd_byte_o = ~b[8];
    endtask

    // Collects nine reply bytes; ok is low on any framing flaw.
    task automatic get_reply(input logic [7:0] instr, output logic [7:0] st,
                             output logic [31:0] v, output logic ok);
        logic [7:0] r [9];
        logic [7:0] sum;
        int n;
        int k;
        n = 0;
        k = 0;
        sum = 8'h00;
        while (n < 9 && k < 200) begin
            rpl_ready_o = !(slow_i && k[0]);
            @(posedge clk_i);
            if (rpl_valid_i === 1'b1 && rpl_ready_o) begin
                r[n] = rpl_byte_i;
                n++;
            end
            #1;
            k++;
        end
        rpl_ready_o = 1'b0;
        for (int i = 0; i < 8; i++) sum += r[i];
        st = r[2];
        v = {r[4], r[5], r[6], r[7]};
        ok = n == 9 && r[0] === HOST_ADDR && r[1] === TARGET_ADDR &&
             r[3] === instr && r[8] === sum;
    endtask
endmodule
`default_nettype wire

// [tb/iracc_core_tb.sv]
// Purpose: Self-checking bench for the command executor.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Expected accumulator values are tracked in the bench.
`timescale 1ns/1ps
`default_nettype none
module iracc_core_tb;
    import iracc_pkg::*;
    localparam logic [7:0] TGT = 8'h01;
    localparam logic [7:0] HST = 8'h02;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic standalone_i = 1'b0;
    iracc_cmd_t prog_cmd_i = '0;
    logic prog_valid_i = 1'b0;
    logic [7:0] din_i = 8'h00;
    logic enable_i = 1'b0;
    logic [7:0][9:0] adc_raw_i = '0;
    logic [15:0] supply_dv_i = 16'h0000;
    logic [15:0] temp_c_i = 16'h0000;
    logic slow = 1'b0;
    logic [7:0] cmd_byte, rpl_byte, dout_o;
    logic cmd_valid, cmd_ready, rpl_ready, rpl_valid;
    logic [31:0] acc_o;
    logic [31:0] exp_acc = 32'h0;
    int n_mismatch = 0;
    int compares = 0;

    always #12.5 clk_i = ~clk_i;

    iracc_core #(.TARGET_ADDR(TGT), .HOST_ADDR(HST)) u_iracc_core (
        .clk_i(clk_i), .rst_i(rst_i), .standalone_i(standalone_i),
        .cmd_byte_i(cmd_byte), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .prog_cmd_i(prog_cmd_i),
        .prog_valid_i(prog_valid_i), .din_i(din_i), .enable_i(enable_i),
        .adc_raw_i(adc_raw_i), .supply_dv_i(supply_dv_i),
        .temp_c_i(temp_c_i), .rpl_ready_i(rpl_ready),
        .rpl_byte_o(rpl_byte), .rpl_valid_o(rpl_valid), .dout_o(dout_o),
        .acc_o(acc_o));

    iracc_host_model #(.HOST_ADDR(HST), .TARGET_ADDR(TGT)) u_iracc_host_model (
        .clk_i(clk_i), .slow_i(slow), .cmd_ready_i(cmd_ready),
        .cmd_byte_o(cmd_byte), .cmd_valid_o(cmd_valid),
        .rpl_byte_i(rpl_byte), .rpl_valid_i(rpl_valid),
        .rpl_ready_o(rpl_ready));

    // One comparison; an unknown never matches.
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // One direct command and its reply, judged on framing, status, value.
    task automatic dx(input logic [7:0] ins, input logic [7:0] typ,
                      input logic [7:0] bank, input logic [31:0] val,
                      input logic [31:0] exp);
        logic [7:0] st;
        logic [31:0] v;
        logic ok;
        u_iracc_host_model.send_frame('{TGT, ins, typ, bank, val}, 8'h00);
        u_iracc_host_model.get_reply(ins, st, v, ok);
        check("reply framing", 32'h1, {31'h0, ok});
        check("reply status", {24'h0, STATUS_OK}, {24'h0, st});
        check("reply value", exp, v);
    endtask

    // Loads, then walks every operation once on a running accumulator.
    task automatic t_math();
        logic [31:0] opnd [10] = '{32'h18, 32'h4, 32'h3, 32'h7, 32'h64,
            32'h2D, 32'h40, 32'hFF, 32'h0, 32'h3E8};
        int o;
        for (int i = 0; i < 10; i++) begin
            o = (i + 9) % 10;
            case (o)
                0: exp_acc = exp_acc + opnd[o];
                1: exp_acc = exp_acc - opnd[o];
                2: exp_acc = exp_acc * opnd[o];
                3: exp_acc = exp_acc / opnd[o];
                4: exp_acc = exp_acc % opnd[o];
                5: exp_acc = exp_acc & opnd[o];
                6: exp_acc = exp_acc | opnd[o];
                7: exp_acc = exp_acc ^ opnd[o];
                8: exp_acc = ~exp_acc;
                default: exp_acc = opnd[o];
            endcase
            dx(INSTR_MATH, 8'(o), 8'h00, opnd[o], opnd[o]);
            check("accumulator", exp_acc, acc_o);
        end
        $display("calculate test done");
    endtask

    // Whole-vector writes, per-line read back, input vector to outputs.
    task automatic t_outputs();
        logic [7:0] pat = 8'hC3;
        dx(INSTR_SET, PORT_ALL, BANK_DOUT, 32'hC3, 32'h0);
        check("outputs", 32'hC3, {24'h0, dout_o});
        for (int p = 0; p < 8; p++) begin
            dx(INSTR_READ, 8'(p), BANK_DOUT, 32'h0, {31'h0, pat[p]});
        end
        // A single line set must touch only that line.
        dx(INSTR_SET, 8'h02, BANK_DOUT, 32'h1, 32'h0);
        check("output line 2", 32'hC7, {24'h0, dout_o});
        dx(INSTR_READ, 8'h02, BANK_DOUT, 32'h0, 32'h1);
        din_i = 8'h3C;
        dx(INSTR_READ, PORT_ALL, BANK_DIN, 32'h0, 32'h3C);
        check("acc from inputs", 32'h3C, acc_o);
        dx(INSTR_SET, PORT_ALL, BANK_DOUT, VALUE_FROM_ACC, 32'h0);
        check("outputs from acc", 32'h3C, {24'h0, dout_o});
        exp_acc = 32'h3C;
        $display("output test done");
    endtask

    // Digital lines and enable; a junk value field must be ignored.
    task automatic t_digital();
        din_i = 8'h5A;
        enable_i = 1'b1;
        for (int p = 0; p < 8; p++) begin
            dx(INSTR_READ, 8'(p), BANK_DIN, 32'hFF00, 32'(din_i[p]));
        end
        dx(INSTR_READ, PORT_ENABLE, BANK_DIN, 32'h0, 32'h1);
        enable_i = 1'b0;
        dx(INSTR_READ, PORT_ENABLE, BANK_DIN, 32'h0, 32'h0);
        check("acc kept", exp_acc, acc_o);
        $display("digital test done");
    endtask

    // Converter reads with a stalling host, full-scale on the last channel.
    task automatic t_adc();
        slow = 1'b1;
        for (int p = 0; p < 8; p++) adc_raw_i[p] = 10'(p * 131 + 1);
        adc_raw_i[7] = 10'h3FF;
        supply_dv_i = 16'h00F0;
        temp_c_i = 16'h0019;
        for (int p = 0; p < 8; p++) begin
            dx(INSTR_READ, 8'(p), BANK_ADC, '0, 32'(adc_raw_i[p]));
        end
        dx(INSTR_READ, PORT_SUPPLY, BANK_ADC, 32'h0, 32'hF0);
        dx(INSTR_READ, PORT_TEMP, BANK_ADC, 32'h0, 32'h19);
        slow = 1'b0;
        $display("converter test done");
    endtask

    // Back-to-back program commands, one per cycle.
    task automatic t_prog();
        standalone_i = 1'b1;
        adc_raw_i[3] = 10'h2A7;
        prog_cmd_i = '{8'h00, INSTR_READ, 8'h03, BANK_ADC, 32'h0};
        prog_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        check("acc after read", 32'h2A7, acc_o);
        prog_cmd_i = '{8'h00, INSTR_MATH, OP_ADD, 8'h00, 32'h5};
        @(posedge clk_i);
        #1;
        check("acc after add", 32'h2AC, acc_o);
        prog_cmd_i = '{8'h00, INSTR_READ, PORT_ALL, BANK_DIN, 32'h0};
        @(posedge clk_i);
        #1;
        prog_valid_i = 1'b0;
        check("acc after vector", {24'h0, din_i}, acc_o);
        standalone_i = 1'b0;
        $display("program test done");
    endtask

    // A spoilt checksum, then a frame in program mode: neither is answered.
    task automatic t_refuse();
        logic seen;
        for (int i = 0; i < 2; i++) begin
            standalone_i = i[0];
            u_iracc_host_model.send_frame('{TGT, INSTR_READ, 8'h00, BANK_DIN,
                32'h0}, i ? 8'h00 : 8'h01);
            seen = 1'b0;
            repeat (3) begin
                @(posedge clk_i);
                seen |= rpl_valid === 1'b1;
            end
            #1;
            check("no reply", 32'h0, {31'h0, seen});
            check("ready back", 32'h1, {31'h0, cmd_ready});
        end
        standalone_i = 1'b0;
        $display("refusal test done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence after a two-cycle reset.
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        check("acc reset", 32'h0, acc_o);
        check("outputs reset", 32'h0, {24'h0, dout_o});
        check("ready after reset", 32'h1, {31'h0, cmd_ready});
        t_math();
        t_outputs();
        t_digital();
        t_adc();
        t_prog();
        t_refuse();
        give_verdict();
    end

    // The whole run needs about a thousand cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
